/* File: isdp_pkg.sv */
// Constants, types and encodings shared by the subtract and multiply datapath.
package isdp_pkg;

  localparam logic [5:0] OPX_SUB      = 6'h04;
  localparam logic [5:0] OPX_SUBCC    = 6'h14;
  localparam logic [5:0] OPX_SUBX     = 6'h0C;
  localparam logic [5:0] OPX_SUBXCC   = 6'h1C;
  localparam logic [5:0] OPX_TSUBCC   = 6'h21;
  localparam logic [5:0] OPX_TSUBCCTV = 6'h23;
  localparam logic [5:0] OPX_MULSCC   = 6'h24;
  localparam logic [5:0] OPX_UMUL     = 6'h0A;
  localparam logic [5:0] OPX_SMUL     = 6'h0B;
  localparam logic [5:0] OPX_UMULCC   = 6'h1A;
  localparam logic [5:0] OPX_SMULCC   = 6'h1B;

  localparam int         IMM_W        = 13;
  localparam int         IMM_SIGN_POS = 12;
  localparam int         TAG_W        = 2;

  localparam logic [31:0] FLAGS_OFFSET = 32'h0000_0000;
  localparam logic [31:0] UPPER_OFFSET = 32'h0000_0004;
  localparam logic [31:0] TRAPS_OFFSET = 32'h0000_0008;
  localparam int          FLAGS_LSB    = 0;
  localparam int          FLAGS_W      = 4;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  localparam logic [31:0] UPPER_RESET  = 32'h0000_0000;
  localparam logic [3:0]  FLAGS_RESET  = 4'h0;
  localparam logic [15:0] TRAPS_RESET  = 16'h0000;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } isdp_icc_s;

  typedef struct packed {
    logic                   valid;
    logic [5:0]             opcode_extension_field;
    logic                   imm_sel;
    logic [IMM_W-1:0]       short_immediate_field;
    logic [31:0]            first_source_value;
    logic [31:0]            second_source_value;
  } isdp_req_s;

  typedef struct packed {
    logic        valid;
    logic        write_dest;
    logic        tag_trap;
    logic        illegal;
    logic [31:0] data;
  } isdp_res_s;

  typedef struct packed {
    logic [31:0] upper;
    isdp_icc_s   icc;
    isdp_res_s   res;
    logic [15:0] traps;
    logic        aw_got;
    logic [31:0] aw_addr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } isdp_state_s;

endpackage

/* File: isdp_datapath.sv */
// Subtract, tagged subtract, multiply-step and full multiply unit with register port.
`timescale 1ns/10ps
module isdp_datapath
  import isdp_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire isdp_req_s   REQ,
  output      isdp_res_s   RES,
  output      isdp_icc_s   FLAGS,
  output      logic [31:0] UPPER_PRODUCT,
  input  wire logic        S_AXI_AWVALID,
  output      logic        S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_WVALID,
  output      logic        S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output      logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output      logic [1:0]  S_AXI_BRESP,
  input  wire logic        S_AXI_ARVALID,
  output      logic        S_AXI_ARREADY,
  input  wire logic [31:0] S_AXI_ARADDR,
  output      logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output      logic [31:0] S_AXI_RDATA,
  output      logic [1:0]  S_AXI_RRESP
);

  isdp_state_s q;
  isdp_state_s d;

  logic               fire_w;
  logic [31:0]        src1_w;
  logic [31:0]        op2_w;
  logic               cin_w;
  logic [32:0]        diff_w;
  logic               sub_v_w;
  logic               tag_w;
  logic               nv_w;
  logic [31:0]        msh_w;
  logic [31:0]        madd_w;
  logic [32:0]        msum_w;
  logic               mv_w;
  logic               sx_w;
  logic signed [65:0] pfull_w;
  logic [63:0]        prod_w;
  logic               flag_wr_w;
  logic               aw_hs_w;
  logic               w_hs_w;
  logic               ar_hs_w;
  logic [5:0]         opx_w;
  logic [31:0]        upper_w;
  logic               c_w;
  logic               wr_do_w;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign opx_w   = REQ.opcode_extension_field;
  assign fire_w  = CE && REQ.valid;
  assign src1_w  = REQ.first_source_value;
  assign upper_w = q.upper;
  assign c_w     = q.icc.c;
  assign op2_w   = REQ.imm_sel ?
                   {{(32-IMM_W){REQ.short_immediate_field[IMM_SIGN_POS]}},
                    REQ.short_immediate_field} : REQ.second_source_value;

  // Carry enters only for the extended forms.
  assign cin_w   = ((opx_w == OPX_SUBX) || (opx_w == OPX_SUBXCC)) ? q.icc.c : 1'b0;
  assign diff_w  = {1'b0, src1_w} - {1'b0, op2_w} - {32'h0000_0000, cin_w};
  assign sub_v_w = (src1_w[31] ^ op2_w[31]) & (diff_w[31] ^ src1_w[31]);
  assign tag_w   = (|src1_w[TAG_W-1:0]) | (|op2_w[TAG_W-1:0]) | sub_v_w;

  assign nv_w    = q.icc.n ^ q.icc.v;
  assign msh_w   = {nv_w, src1_w[31:1]};
  assign madd_w  = q.upper[0] ? op2_w : 32'h0000_0000;
  assign msum_w  = {1'b0, msh_w} + {1'b0, madd_w};
  assign mv_w    = (msh_w[31] == madd_w[31]) & (msum_w[31] != msh_w[31]);

  // A 33x33 signed product serves both signednesses without a second multiplier.
  assign sx_w    = (opx_w == OPX_SMUL) || (opx_w == OPX_SMULCC);
  assign pfull_w = $signed({sx_w & src1_w[31], src1_w}) *
                   $signed({sx_w & op2_w[31], op2_w});
  assign prod_w  = pfull_w[63:0];

  assign aw_hs_w = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_hs_w  = S_AXI_WVALID && S_AXI_WREADY;
  assign ar_hs_w = S_AXI_ARVALID && S_AXI_ARREADY;
  assign wr_do_w   = q.aw_got && q.w_got && !q.bvalid;
  assign flag_wr_w = wr_do_w && (q.aw_addr == FLAGS_OFFSET);

  always_comb begin
    d = q;
    d.res.valid = 1'b0;

    // Register port: address and data may arrive in either order.
    if (aw_hs_w) begin
      d.aw_got  = 1'b1;
      d.aw_addr = S_AXI_AWADDR;
    end
    if (w_hs_w) begin
      d.w_got = 1'b1;
      d.wdata = S_AXI_WDATA;
      d.wstrb = S_AXI_WSTRB;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      if (q.aw_addr == FLAGS_OFFSET) begin
        if (q.wstrb[0]) begin
          d.icc = isdp_icc_s'(q.wdata[FLAGS_LSB +: FLAGS_W]);
        end
      end else if (q.aw_addr == UPPER_OFFSET) begin
        d.upper = merge_bytes(q.upper, q.wdata, q.wstrb);
      end else if (q.aw_addr != TRAPS_OFFSET) begin
        d.bresp = RESP_SLVERR;
      end
    end
    if (q.bvalid && S_AXI_BREADY) begin
      d.bvalid = 1'b0;
    end
    if (ar_hs_w) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      if (S_AXI_ARADDR == FLAGS_OFFSET) begin
        d.rdata = {28'h000_0000, q.icc};
      end else if (S_AXI_ARADDR == UPPER_OFFSET) begin
        d.rdata = q.upper;
      end else if (S_AXI_ARADDR == TRAPS_OFFSET) begin
        d.rdata = {16'h0000, q.traps};
      end else begin
        d.rdata = 32'h0000_0000;
        d.rresp = RESP_SLVERR;
      end
    end else if (q.rvalid && S_AXI_RREADY) begin
      d.rvalid = 1'b0;
    end

    // An instruction in the same cycle as a register write wins the flags and upper word.
    if (REQ.valid) begin
      d.res.valid      = 1'b1;
      d.res.write_dest = 1'b1;
      d.res.tag_trap   = 1'b0;
      d.res.illegal    = 1'b0;
      d.res.data       = diff_w[31:0];
      case (opx_w)
        OPX_SUB, OPX_SUBX: begin
          d.res.data = diff_w[31:0];
        end
        OPX_SUBCC, OPX_SUBXCC: begin
          d.icc = '{n: diff_w[31], z: (diff_w[31:0] == 32'h0000_0000),
                    v: sub_v_w, c: diff_w[32]};
        end
        OPX_TSUBCC: begin
          d.icc = '{n: diff_w[31], z: (diff_w[31:0] == 32'h0000_0000),
                    v: tag_w, c: diff_w[32]};
        end
        OPX_TSUBCCTV: begin
          if (tag_w) begin
            d.res.write_dest = 1'b0;
            d.res.tag_trap   = 1'b1;
            d.traps          = 16'(q.traps + 16'h0001);
          end else begin
            d.icc = '{n: diff_w[31], z: (diff_w[31:0] == 32'h0000_0000),
                      v: 1'b0, c: diff_w[32]};
          end
        end
        OPX_MULSCC: begin
          d.res.data = msum_w[31:0];
          d.icc = '{n: msum_w[31], z: (msum_w[31:0] == 32'h0000_0000),
                    v: mv_w, c: msum_w[32]};
          d.upper = {src1_w[0], q.upper[31:1]};
        end
        OPX_UMUL, OPX_SMUL: begin
          d.res.data = prod_w[31:0];
          d.upper    = prod_w[63:32];
        end
        OPX_UMULCC, OPX_SMULCC: begin
          d.res.data = prod_w[31:0];
          d.upper    = prod_w[63:32];
          d.icc = '{n: prod_w[31], z: (prod_w[31:0] == 32'h0000_0000),
                    v: 1'b0, c: 1'b0};
        end
        default: begin
          // Codes outside this unit are reported back and write nothing.
          d.res.write_dest = 1'b0;
          d.res.illegal    = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      q <= '{upper: UPPER_RESET, icc: isdp_icc_s'(FLAGS_RESET), res: '0,
             traps: TRAPS_RESET, aw_addr: 32'h0000_0000, wdata: 32'h0000_0000,
             rdata: 32'h0000_0000, default: '0};
    end else if (CE) begin
      q <= d;
    end
  end

  assign RES           = q.res;
  assign FLAGS         = q.icc;
  assign UPPER_PRODUCT = q.upper;
  // Readies drop with the clock enable, since frozen state cannot take a beat.
  assign S_AXI_AWREADY = CE && !q.aw_got && !q.bvalid;
  assign S_AXI_WREADY  = CE && !q.w_got && !q.bvalid;
  assign S_AXI_BVALID  = q.bvalid;
  assign S_AXI_BRESP   = q.bresp;
  assign S_AXI_ARREADY = CE && !q.rvalid;
  assign S_AXI_RVALID  = q.rvalid;
  assign S_AXI_RDATA   = q.rdata;
  assign S_AXI_RRESP   = q.rresp;

  chk_sub_result: assert property (@(posedge CLK) disable iff (RST)
    fire_w && (opx_w == OPX_SUB) |=> RES.data == $past(src1_w) - $past(op2_w))
    else $error("Plain subtract result wrong.");

  chk_subx_carry: assert property (@(posedge CLK) disable iff (RST)
    fire_w && (opx_w == OPX_SUBX)
    |=> RES.data == $past(src1_w) - $past(op2_w) - {31'h0, $past(c_w)})
    else $error("Extended subtract ignored carry.");

  chk_nocc_flags: assert property (@(posedge CLK) disable iff (RST)
    fire_w && !flag_wr_w && ((opx_w == OPX_SUB) || (opx_w == OPX_SUBX) ||
                             (opx_w == OPX_UMUL) || (opx_w == OPX_SMUL))
    |=> $stable(FLAGS))
    else $error("Non-flag operation changed flags.");

  chk_sub_ovf: assert property (@(posedge CLK) disable iff (RST)
    fire_w && (opx_w == OPX_SUBCC) && (src1_w[31] == op2_w[31])
    |=> !FLAGS.v)
    else $error("Overflow set with equal signs.");

  chk_tag_trap: assert property (@(posedge CLK) disable iff (RST)
    fire_w && !wr_do_w && (opx_w == OPX_TSUBCCTV) && (|src1_w[1:0])
    |=> RES.tag_trap && !RES.write_dest && $stable(FLAGS) && $stable(UPPER_PRODUCT))
    else $error("Tag trap did not block update.");

  chk_tag_clean: assert property (@(posedge CLK) disable iff (RST)
    fire_w && (opx_w == OPX_TSUBCCTV) && !tag_w
    |=> !FLAGS.v && RES.write_dest && !RES.tag_trap)
    else $error("Clean trapping tagged subtract wrong.");

  chk_tsub_v: assert property (@(posedge CLK) disable iff (RST)
    fire_w && (opx_w == OPX_TSUBCC)
    |=> (FLAGS.v == $past(tag_w)) && RES.write_dest && !RES.tag_trap)
    else $error("Tagged subtract overflow flag wrong.");

  chk_muls_upper: assert property (@(posedge CLK) disable iff (RST)
    fire_w && (opx_w == OPX_MULSCC)
    |=> UPPER_PRODUCT == {$past(src1_w[0]), $past(upper_w[31:1])})
    else $error("Multiply-step upper shift wrong.");

  chk_muls_noadd: assert property (@(posedge CLK) disable iff (RST)
    fire_w && (opx_w == OPX_MULSCC) && !upper_w[0]
    |=> RES.data == {$past(nv_w), $past(src1_w[31:1])})
    else $error("Multiply-step added when bit was zero.");

  chk_umul_prod: assert property (@(posedge CLK) disable iff (RST)
    fire_w && (opx_w == OPX_UMUL)
    |=> {UPPER_PRODUCT, RES.data} == {32'h0000_0000, $past(src1_w)} *
                                     {32'h0000_0000, $past(op2_w)})
    else $error("Unsigned product wrong.");

  chk_smul_prod: assert property (@(posedge CLK) disable iff (RST)
    fire_w && (opx_w == OPX_SMUL)
    |=> {UPPER_PRODUCT, RES.data} ==
        64'($signed({{32{$past(src1_w[31])}}, $past(src1_w)}) *
            $signed({{32{$past(op2_w[31])}}, $past(op2_w)})))
    else $error("Signed product wrong.");

  chk_mul_flags: assert property (@(posedge CLK) disable iff (RST)
    fire_w && ((opx_w == OPX_UMULCC) || (opx_w == OPX_SMULCC))
    |=> !FLAGS.v && !FLAGS.c && (FLAGS.z == (RES.data == 32'h0000_0000)) &&
        (FLAGS.n == RES.data[31]))
    else $error("Multiply flags wrong.");

endmodule // isdp_datapath

/* File: isdp_partner.sv */
// Partner model: destination write-back and trap tally behind the datapath.
`timescale 1ns/10ps
module isdp_partner
  import isdp_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire isdp_res_s res,
  output logic [31:0]    dest_q,
  output logic [15:0]    trap_q
);
  // Flags after a multiply are never consulted, only the low product word in res.data.
  always_ff @(posedge clk) begin
    if (rst) begin
      dest_q <= 32'h0;
      trap_q <= 16'h0;
    end else if (res.valid) begin
      if (res.write_dest) dest_q <= res.data;
      if (res.tag_trap) trap_q <= trap_q + 16'h1;
    end
  end
endmodule // isdp_partner

/* File: test_integer_sub_mul_datapath.sv */
// Self-checking bench for the subtract and multiply datapath.
`timescale 1ns/10ps
module test_integer_sub_mul_datapath;
  import isdp_pkg::*;
  logic        clk, rst, ce;
  isdp_req_s   req;
  isdp_res_s   res;
  isdp_icc_s   flags, m_f;
  logic [31:0] upper, m_y, m_dest, awa, wdat, ara, rdat, dest_q, tmp;
  logic        awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp;
  logic [15:0] m_traps, trap_q;
  int          n_mismatch, check_count;
  logic [5:0]  ops [12] = '{OPX_SUB, OPX_SUBCC, OPX_SUBX, OPX_SUBXCC, OPX_TSUBCC,
    OPX_TSUBCCTV, OPX_MULSCC, OPX_UMUL, OPX_SMUL, OPX_UMULCC, OPX_SMULCC, 6'h3F};

  isdp_datapath DUT (.CLK(clk), .RST(rst), .CE(ce), .REQ(req), .RES(res), .FLAGS(flags),
    .UPPER_PRODUCT(upper), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_), .S_AXI_WDATA(wdat), .S_AXI_WSTRB(ws),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp));
  isdp_partner partner (.clk(clk), .rst(rst), .res(res), .dest_q(dest_q), .trap_q(trap_q));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Handshakes are judged at the falling edge so that the rising edge never races the design.
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    int t;
    @(posedge clk);
    awv <= 1'h1; wv <= 1'h1; awa <= a; wdat <= d; ws <= 4'hF; br <= 1'h1;
    aw = 1'h0; w = 1'h0; t = 0;
    while (!(aw && w) && t < 50) begin
      @(negedge clk);
      aw = aw | (awr === 1'h1);
      w = w | (wr_ === 1'h1);
      @(posedge clk);
      if (aw) awv <= 1'h0;
      if (w) wv <= 1'h0;
      t++;
    end
    t = 0;
    do begin @(negedge clk); t++; end while (bv !== 1'h1 && t < 50);
    check({bv, bresp}, {1'h1, er});
    @(posedge clk);
    br <= 1'h0;
  endtask

  task automatic bus_rd(input logic [31:0] a, input logic [1:0] er, input logic [31:0] ed);
    int t;
    @(posedge clk);
    arv <= 1'h1; ara <= a; rr <= 1'h1;
    t = 0;
    do begin @(negedge clk); t++; end while (arr !== 1'h1 && t < 50);
    @(posedge clk);
    arv <= 1'h0;
    t = 0;
    do begin @(negedge clk); t++; end while (rv !== 1'h1 && t < 50);
    check({rv, rresp, rdat}, {1'h1, er, ed});
    @(posedge clk);
    rr <= 1'h0;
  endtask

  task automatic run_op(input logic [5:0] op);
    logic [31:0] a, b, d, s;
    logic [32:0] p;
    logic [63:0] pm;
    logic signed [63:0] sa, sb;
    logic ov, tv, wd, tr, il;
    isdp_icc_s f;
    isdp_req_s q;
    q = {1'h1, op, 1'($urandom), 13'($urandom), 32'($urandom), 32'($urandom)};
    if ($urandom % 2) begin
      q.first_source_value[1:0] = 2'h0;
      q.second_source_value[1:0] = 2'h0;
      q.short_immediate_field[1:0] = 2'h0;
    end
    a = q.first_source_value;
    b = q.imm_sel ? {{19{q.short_immediate_field[12]}}, q.short_immediate_field}
                  : q.second_source_value;
    wd = 1'h1; tr = 1'h0; il = 1'h0;
    p = {1'h0, a} - {1'h0, b} - ((op == OPX_SUBX || op == OPX_SUBXCC) & m_f.c);
    d = p[31:0];
    ov = (a[31] != b[31]) && (d[31] != a[31]);
    tv = (a[1:0] != 2'h0) || (b[1:0] != 2'h0) || ov;
    f = {d[31], d == 32'h0, ov, p[32]};
    case (op)
      OPX_SUB, OPX_SUBX: f = m_f;
      OPX_SUBCC, OPX_SUBXCC: ;
      OPX_TSUBCC: f.v = tv;
      OPX_TSUBCCTV: if (tv) begin
        f = m_f; wd = 1'h0; tr = 1'h1; m_traps++;
      end else f.v = 1'h0;
      OPX_MULSCC: begin
        s = {m_f.n ^ m_f.v, a[31:1]};
        p = {1'h0, s} + {1'h0, m_y[0] ? b : 32'h0};
        d = p[31:0];
        f = {d[31], d == 32'h0, s[31] == b[31] && m_y[0] && d[31] != s[31], p[32]};
        m_y = {a[0], m_y[31:1]};
      end
      OPX_UMUL, OPX_UMULCC, OPX_SMUL, OPX_SMULCC: begin
        sa = $signed(a);
        sb = $signed(b);
        if (op[0]) pm = sa * sb;
        else pm = {32'h0, a} * {32'h0, b};
        m_y = pm[63:32];
        d = pm[31:0];
        f = op[4] ? {d[31], d == 32'h0, 2'h0} : m_f;
      end
      default: begin il = 1'h1; wd = 1'h0; f = m_f; end
    endcase
    m_f = f;
    if (wd) m_dest = d;
    @(posedge clk);
    req <= q;
    @(posedge clk);
    req.valid <= 1'h0;
    #1;
    check({res.valid, res.illegal, res.tag_trap}, {1'h1, il, tr});
    check(res.write_dest, wd);
    if (wd) check(res.data, d);
    check(flags, f);
    check(upper, m_y);
    @(posedge clk);
    #1;
    check(dest_q, m_dest);
  endtask

  initial begin
    rst = 1'h1; ce = 1'h1; req = '0; awv = 1'h0; wv = 1'h0; br = 1'h0; arv = 1'h0;
    rr = 1'h0; awa = 32'h0; wdat = 32'h0; ws = 4'h0; ara = 32'h0;
    n_mismatch = 0; check_count = 0; m_f = 4'h0; m_y = 32'h0; m_dest = 32'h0;
    m_traps = 16'h0;
    void'($urandom(14749));
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    bus_rd(FLAGS_OFFSET, RESP_OKAY, 32'h0);
    bus_rd(UPPER_OFFSET, RESP_OKAY, 32'h0);
    bus_rd(TRAPS_OFFSET, RESP_OKAY, 32'h0);
    $display("test reset values done");
    bus_rd(32'h0000_000C, RESP_SLVERR, 32'h0);
    bus_wr(32'h0000_0010, 32'h5, RESP_SLVERR);
    bus_wr(TRAPS_OFFSET, 32'h7, RESP_OKAY);
    bus_rd(TRAPS_OFFSET, RESP_OKAY, 32'h0);
    $display("test register map done");
    // Flags and upper word are reloaded often so carry-in and step inputs vary widely.
    for (int i = 0; i < 400; i++) begin
      if (i % 6 == 0) begin
        tmp = $urandom;
        bus_wr(FLAGS_OFFSET, tmp, RESP_OKAY);
        m_f = tmp[3:0];
        tmp = $urandom;
        bus_wr(UPPER_OFFSET, tmp, RESP_OKAY);
        m_y = tmp;
        bus_rd(FLAGS_OFFSET, RESP_OKAY, {28'h0, m_f});
      end
      run_op(i < 12 ? ops[i] : ops[$urandom % 12]);
    end
    bus_rd(TRAPS_OFFSET, RESP_OKAY, {16'h0, m_traps});
    check(trap_q, m_traps);
    $display("test instruction stream done");
    wrap_up;
  end

  initial begin
    #300000;
    n_mismatch++;
    wrap_up;
  end
endmodule // test_integer_sub_mul_datapath
